// ### core/dfps_top.sv
`timescale 1ns/100ps
`include "dfps_map.svh"
// How it works
// - Output phase loss trips while running above 1Hz
// - Output phase loss enable bit, reset one
// - Input phase loss trips after one second
// - Input phase loss enable bit, reset one
// - Input loss ignored light load or stopped
// - Input loss ignored while regenerating
// - Input loss setting only on three-phase variant
// - Earth check only right after start command
// - Earth check enable bit, reset zero
// - Earth check delays output about 20ms
// - Earth fault found records fault and trips
// - First fault of retry sequence kept, fault code shows latest
// - Retry reset keeps thermal and brake accumulations
// - No retry after power-on storage fault
// - Unselected fault during wait abandons retry
// - Excitation mode zero normal, nine optimum
// - Optimum excitation only under V/F control
// - Optimum excitation suspended during restart
// - Settings other than group select writable only when group select zero
// - Retry wait configurable 0.1 to 360s
module dfps_top
  import dfps_pkg::*;
#(
  parameter bit          THREE_PHASE = 1'b1,
  parameter int unsigned IN_LOSS_CYC = `DFPS_CYC(`DFPS_IN_LOSS_US),
  parameter int unsigned EARTH_CYC   = `DFPS_CYC(`DFPS_EARTH_US),
  parameter int unsigned TENTH_CYC   = `DFPS_CYC(`DFPS_TENTH_US)
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  // Drive conditions and retry selection
  input  wire dfps_drive_t DRIVE,
  input  wire dfps_retry_t RETRY,
  input  wire logic        START_CMD,
  // Plant sense pins
  input  wire logic        OUT_PHASE_LOST,
  input  wire logic        IN_PHASE_LOST,
  input  wire logic        EARTH_FAULT,
  input  wire logic        PARAM_STORE_FAULT,
  // Outputs to the drive
  output logic             OUTPUT_ENABLE,
  output logic             FAULT_OUT,
  output logic             RETRY_RESET,
  output logic             OPTIMUM_EXCITATION,
  output logic [3:0]       FAULT_CODE
);
  // ==========================================================
  // Pin synchronisers
  logic [3:0] sync_a;                 // First stage
  logic [3:0] sync_b;                 // Second stage
  logic       out_lost;               // Synced output phase loss
  logic       in_lost;                // Synced input phase loss
  logic       earth;                  // Synced earth fault
  logic       store_fault;            // Synced storage fault

  // Two flops per pin
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {PARAM_STORE_FAULT, EARTH_FAULT, IN_PHASE_LOST, OUT_PHASE_LOST};
      sync_b <= sync_a;
    end
  end
  assign out_lost    = sync_b[0];
  assign in_lost     = sync_b[1];
  assign earth       = sync_b[2];
  assign store_fault = sync_b[3];

  // ==========================================================
  // Settings
  logic [2:0]  ctrl;                  // Enable bits
  logic [3:0]  mode;                  // Excitation mode select
  logic [11:0] wait_time;             // Retry wait, tenths of s
  logic [3:0]  group_sel;             // User group read select
  logic        write_ok;              // Settings writable
  logic        wr_ctrl;               // Control write
  logic        wr_mode;               // Mode write
  logic        wr_wait;               // Wait write
  logic        wr_group;              // Group select write
  logic        wr_cmd;                // Command write
  logic [11:0] wait_clamped;          // Written wait clamped to range

  // Group select zero opens the other settings
  assign write_ok = (group_sel == 4'h0);
  assign wr_ctrl  = WR && write_ok && (ADDR == `DFPS_ADDR_CTRL);
  assign wr_mode  = WR && write_ok && (ADDR == `DFPS_ADDR_MODE);
  assign wr_wait  = WR && write_ok && (ADDR == `DFPS_ADDR_WAIT);
  assign wr_group = WR && (ADDR == `DFPS_ADDR_GROUP);
  assign wr_cmd   = WR && (ADDR == `DFPS_ADDR_CMD);
  // Keep the wait between 0.1 and 360 s
  assign wait_clamped = (WDATA[11:0] < `DFPS_WAIT_MIN) ? `DFPS_WAIT_MIN :
                        (WDATA[11:0] > `DFPS_WAIT_MAX) ? `DFPS_WAIT_MAX : WDATA[11:0];

  // Settings registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl      <= `DFPS_CTRL_RESET;
      mode      <= `DFPS_MODE_RESET;
      wait_time <= `DFPS_WAIT_RESET;
      group_sel <= `DFPS_GROUP_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl[`DFPS_CTRL_OUT_EN]   <= WDATA[`DFPS_CTRL_OUT_EN];
        // Input loss bit written as zero on single-phase variants
        ctrl[`DFPS_CTRL_IN_EN]    <= WDATA[`DFPS_CTRL_IN_EN] & THREE_PHASE;
        ctrl[`DFPS_CTRL_EARTH_EN] <= WDATA[`DFPS_CTRL_EARTH_EN];
      end
      // Only the two documented modes are accepted
      if (wr_mode && (WDATA[3:0] == 4'h0 || WDATA[3:0] == `DFPS_MODE_OPTIMUM)) begin
        mode <= WDATA[3:0];
      end
      if (wr_wait) begin
        wait_time <= wait_clamped;
      end
      if (wr_group) begin
        group_sel <= WDATA[3:0];
      end
    end
  end

  // Effective enables
  logic out_en;                       // Output loss protection on
  logic in_en;                        // Input loss protection on
  logic earth_en;                     // Earth check on
  assign out_en   = ctrl[`DFPS_CTRL_OUT_EN];
  assign in_en    = ctrl[`DFPS_CTRL_IN_EN] & THREE_PHASE;
  assign earth_en = ctrl[`DFPS_CTRL_EARTH_EN];

  // ==========================================================
  // Fault detection
  logic        out_trip;              // Output loss condition
  logic        in_watch;              // Input loss may be judged
  logic [31:0] in_cnt;                // Input loss persistence
  logic        in_trip;               // Input loss held one second

  // Output loss only while running, not braking, above 1Hz
  assign out_trip = out_en && out_lost && DRIVE.running &&
                    !DRIVE.dc_braking && DRIVE.freq_above_1hz;
  // Bus ripple method is blind when stopped, light or regenerating
  assign in_watch = in_en && DRIVE.running && !DRIVE.light_load &&
                    !DRIVE.regenerating;
  assign in_trip  = (in_cnt >= IN_LOSS_CYC - 1) && in_watch && in_lost;

  // Continuous loss counter, restarts on any gap
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      in_cnt <= 32'h0;
    end else if (in_watch && in_lost) begin
      if (in_cnt < IN_LOSS_CYC - 1) begin
        in_cnt <= in_cnt + 32'h1;
      end
    end else begin
      in_cnt <= 32'h0;
    end
  end

  // ==========================================================
  // Sequencer
  dfps_state_t state;                 // Current state
  dfps_state_t next_state;            // Next state
  logic [31:0] timer;                 // Check and wait timer
  logic [11:0] tenths;                // Elapsed tenths of a second
  logic        start_q;               // Start command, previous
  logic        start_edge;            // Start command rising
  logic        power_on_store;        // Storage fault seen at power on
  logic [1:0]  po_cnt;                // Edges since release, saturates
  logic        in_sequence;           // Retry sequence active
  logic        new_fault;             // Any trip this cycle
  logic [3:0]  new_code;              // Code of that trip
  logic        retryable;             // New fault may be retried
  logic [3:0]  retry_code;            // Code judged for retry
  logic [15:0] accum_resets;          // Resets that clear accumulations
  logic [3:0]  first_code;            // First fault of sequence

  assign start_edge = START_CMD && !start_q;
  // Earth fault counts only during the start check window
  assign new_fault = ((state == DFPS_RUN) && (out_trip || in_trip)) ||
                     ((state == DFPS_CHECK) && earth) ||
                     ((state != DFPS_TRIP) && (store_fault || RETRY.ext_fault));
  assign new_code  = (state == DFPS_CHECK && earth) ? `DFPS_CODE_EARTH :
                     store_fault                    ? `DFPS_CODE_STORE :
                     (state == DFPS_RUN && out_trip) ? `DFPS_CODE_OUT_LOSS :
                     (state == DFPS_RUN && in_trip)  ? `DFPS_CODE_IN_LOSS : `DFPS_CODE_EXT;
  // Storage fault from power on never retries
  // In TRIP the latched code decides, since the pin may have dropped
  assign retry_code = (state == DFPS_TRIP) ? FAULT_CODE : new_code;
  assign retryable = RETRY.retry_enable && RETRY.ext_retry_ok &&
                     !(retry_code == `DFPS_CODE_STORE && power_on_store);

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      DFPS_IDLE: begin
        if (new_fault) begin
          next_state = DFPS_TRIP;
        end else if (start_edge) begin
          next_state = earth_en ? DFPS_CHECK : DFPS_RUN;
        end
      end
      DFPS_CHECK: begin
        if (new_fault) begin
          next_state = DFPS_TRIP;
        end else if (timer >= EARTH_CYC - 1) begin
          next_state = DFPS_RUN;
        end
      end
      DFPS_RUN: begin
        if (new_fault) begin
          next_state = DFPS_TRIP;
        end else if (!START_CMD) begin
          next_state = DFPS_IDLE;
        end
      end
      DFPS_TRIP: begin
        if (wr_cmd && WDATA[`DFPS_CMD_RESET]) begin
          next_state = DFPS_IDLE;
        end else if (retryable) begin
          next_state = DFPS_WAIT;
        end
      end
      DFPS_WAIT: begin
        if (new_fault && !retryable) begin
          next_state = DFPS_TRIP;
        end else if (tenths >= wait_time) begin
          next_state = DFPS_IDLE;
        end
      end
      default: begin
        next_state = DFPS_IDLE;
      end
    endcase
  end

  // State, timers and power-on capture
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state          <= DFPS_IDLE;
      timer          <= 32'h0;
      tenths         <= 12'h0;
      start_q        <= 1'b0;
      power_on_store <= 1'b0;
      po_cnt         <= 2'h0;
    end else begin
      state      <= next_state;
      start_q    <= START_CMD;
      if (po_cnt != 2'h3) begin
        po_cnt <= po_cnt + 2'h1;
      end
      // Synced pin first shows its power-on level at the third edge
      if (po_cnt == 2'h2) begin
        power_on_store <= store_fault;
      end
      if (next_state != state) begin
        timer  <= 32'h0;
        tenths <= 12'h0;
      end else if (timer >= TENTH_CYC - 1 && state == DFPS_WAIT) begin
        timer  <= 32'h0;
        tenths <= tenths + 12'h1;
      end else begin
        timer <= timer + 32'h1;
      end
    end
  end

  // Fault record and retry bookkeeping
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      first_code   <= `DFPS_CODE_NONE;
      in_sequence  <= 1'b0;
      accum_resets <= 16'h0;
      FAULT_CODE   <= `DFPS_CODE_NONE;
      FAULT_OUT    <= 1'b0;
      RETRY_RESET  <= 1'b0;
    end else begin
      RETRY_RESET <= (state == DFPS_WAIT) && (next_state == DFPS_IDLE);
      if (new_fault && next_state == DFPS_TRIP || new_fault && state == DFPS_IDLE) begin
        FAULT_CODE <= new_code;
        FAULT_OUT  <= 1'b1;
        if (!in_sequence) begin
          first_code  <= new_code;
          in_sequence <= 1'b1;
        end
      end
      if (wr_cmd && WDATA[`DFPS_CMD_RESET] && state == DFPS_TRIP) begin
        FAULT_OUT   <= 1'b0;
        FAULT_CODE  <= `DFPS_CODE_NONE;
        in_sequence <= 1'b0;
        // Manual reset clears accumulations; retry reset does not
        accum_resets <= accum_resets + 16'h1;
      end else if (state == DFPS_WAIT && next_state == DFPS_IDLE) begin
        FAULT_OUT  <= 1'b0;
        FAULT_CODE <= `DFPS_CODE_NONE;
      end else if (state == DFPS_RUN && !START_CMD && !new_fault) begin
        in_sequence <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outputs and read port
  logic [15:0] next_rdata;            // Read mux

  assign next_rdata =
    (ADDR == `DFPS_ADDR_CTRL)   ? {13'h0, ctrl} :
    (ADDR == `DFPS_ADDR_MODE)   ? {12'h0, mode} :
    (ADDR == `DFPS_ADDR_WAIT)   ? {4'h0, wait_time} :
    (ADDR == `DFPS_ADDR_GROUP)  ? {12'h0, group_sel} :
    (ADDR == `DFPS_ADDR_STATUS) ? {9'h0, power_on_store, in_sequence, FAULT_OUT, 1'b0, state} :
    (ADDR == `DFPS_ADDR_FIRST)  ? {12'h0, first_code} :
    (ADDR == `DFPS_ADDR_ACCUM)  ? accum_resets : 16'h0;

  // Registered outputs
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RDATA              <= 16'h0;
      OUTPUT_ENABLE      <= 1'b0;
      OPTIMUM_EXCITATION <= 1'b0;
    end else begin
      RDATA         <= RD ? next_rdata : 16'h0;
      // Output held off in check window and any trip
      OUTPUT_ENABLE <= (next_state == DFPS_RUN);
      OPTIMUM_EXCITATION <= (mode == `DFPS_MODE_OPTIMUM) && DRIVE.vf_control &&
                            !DRIVE.restart_active;
    end
  end

  // ==========================================================
  // Checks
  trip_holds_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == DFPS_TRIP |=> !OUTPUT_ENABLE) else $error("output on during trip");
  check_delay_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(state == DFPS_CHECK) |-> !OUTPUT_ENABLE[*8]) else $error("output during check");
  opt_vf_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
    OPTIMUM_EXCITATION |-> $past(DRIVE.vf_control) && !$past(DRIVE.restart_active))
    else $error("optimum excitation wrongly on");
  group_lock_a: assert property (@(posedge CLK) disable iff (!RST_N)
    group_sel != 4'h0 |=> $stable(ctrl)) else $error("settings changed while locked");
  earth_start_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == DFPS_RUN && earth && !store_fault && !RETRY.ext_fault && !out_trip && !in_trip
    |=> state == DFPS_RUN || state == DFPS_IDLE) else $error("earth trip while running");
  out_loss_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
    out_trip |-> DRIVE.freq_above_1hz && !DRIVE.dc_braking) else $error("loss trip gated wrong");
  store_no_retry_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == DFPS_TRIP && power_on_store && FAULT_CODE == `DFPS_CODE_STORE
    |=> state != DFPS_WAIT) else $error("retry after storage fault");
  wait_abandon_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == DFPS_WAIT && new_fault && !retryable |=> state == DFPS_TRIP)
    else $error("retry not abandoned");
endmodule : dfps_top

// ### core/dfps_map.svh
`ifndef DFPS_MAP_SVH
`define DFPS_MAP_SVH
// ==========================================================
// Register offsets (word addresses on the plain port)
`define DFPS_ADDR_CTRL     4'h0
`define DFPS_ADDR_MODE     4'h1
`define DFPS_ADDR_WAIT     4'h2
`define DFPS_ADDR_GROUP    4'h3
`define DFPS_ADDR_STATUS   4'h4
`define DFPS_ADDR_FIRST    4'h5
`define DFPS_ADDR_ACCUM    4'h6
`define DFPS_ADDR_CMD      4'h7
// ==========================================================
// Control register bit positions
`define DFPS_CTRL_OUT_EN   0
`define DFPS_CTRL_IN_EN    1
`define DFPS_CTRL_EARTH_EN 2
// Command register bit positions
`define DFPS_CMD_RESET     0
// ==========================================================
// Reset values and the optimum mode code
`define DFPS_CTRL_RESET    3'h3
`define DFPS_MODE_RESET    4'h0
`define DFPS_WAIT_RESET    12'h00a
`define DFPS_GROUP_RESET   4'h0
`define DFPS_MODE_OPTIMUM  4'h9
// ==========================================================
// Wait time limits in tenths of a second
`define DFPS_WAIT_MIN      12'h001
`define DFPS_WAIT_MAX      12'he10
// ==========================================================
// Timing: clock in Hz, times in microseconds
`define DFPS_CLK_HZ        40000000
`define DFPS_IN_LOSS_US    1000000
`define DFPS_EARTH_US      20000
`define DFPS_TENTH_US      100000
`define DFPS_CYC(us)       ((`DFPS_CLK_HZ / 1000000) * (us))
// Fault codes
`define DFPS_CODE_NONE     4'h0
`define DFPS_CODE_OUT_LOSS 4'h1
`define DFPS_CODE_IN_LOSS  4'h2
`define DFPS_CODE_EARTH    4'h3
`define DFPS_CODE_STORE    4'h4
`define DFPS_CODE_EXT      4'h5
`endif

// ### core/dfps_pkg.sv
package dfps_pkg;
  // ==========================================================
  // Protection sequencer states
  typedef enum logic [2:0] {
    DFPS_IDLE  = 3'b000,
    DFPS_CHECK = 3'b001,
    DFPS_RUN   = 3'b010,
    DFPS_TRIP  = 3'b011,
    DFPS_WAIT  = 3'b100
  } dfps_state_t;

  // Drive condition flags from the motor control logic
  typedef struct packed {
    logic       running;
    logic       dc_braking;
    logic       regenerating;
    logic       light_load;
    logic       restart_active;
    logic       vf_control;
    logic       freq_above_1hz;
  } dfps_drive_t;

  // Retry selection and external faults
  typedef struct packed {
    logic       ext_fault;
    logic       ext_retry_ok;
    logic       retry_enable;
  } dfps_retry_t;
endpackage : dfps_pkg

// ### tb/dfps_plant.sv
`timescale 1ns/100ps
// ==========================================================
// Plant model: motor load and three-phase mains sense lines
module dfps_plant (
  // Clock
  input  wire logic CLK,
  // Plant conditions set by the bench
  input  wire logic brk_o,
  input  wire logic brk_i,
  input  wire logic leak,
  input  wire logic bad,
  // Sense lines toward the drive
  output logic      olo,
  output logic      ilo,
  output logic      eft,
  output logic      psf
);
  // Plant answers one clock after a condition changes
  always_ff @(posedge CLK) begin
    olo <= brk_o;
    ilo <= brk_i;
    eft <= leak;
    psf <= bad;
  end
endmodule : dfps_plant

// ### tb/dfps_tb_top.sv
`timescale 1ns/100ps
`include "dfps_map.svh"
// ==========================================================
// Bench for the protection selector
module dfps_tb_top
  import dfps_pkg::*;
;
  localparam int EC = 10;             // Shortened earth check
  logic        clk, rst_n, wr, rd;    // Clock, reset, strobes
  logic        start, brk_o, brk_i;   // Run command, plant faults
  logic        leak, bad, got;        // Plant faults, wait result
  logic [3:0]  addr, code;            // Register address, fault code
  logic [15:0] wdata, rdata, v, a0;   // Bus data and captures
  logic        oe, flt, rr, opt;      // Drive outputs
  logic        olo, ilo, eft, psf;    // Sense lines
  dfps_drive_t drive;                 // Drive conditions
  dfps_retry_t retry;                 // Retry selection
  int          err_total, samples_checked;

  dfps_top #(.IN_LOSS_CYC(20), .EARTH_CYC(EC), .TENTH_CYC(5)) dut (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .DRIVE(drive), .RETRY(retry), .START_CMD(start),
    .OUT_PHASE_LOST(olo), .IN_PHASE_LOST(ilo), .EARTH_FAULT(eft),
    .PARAM_STORE_FAULT(psf), .OUTPUT_ENABLE(oe), .FAULT_OUT(flt),
    .RETRY_RESET(rr), .OPTIMUM_EXCITATION(opt), .FAULT_CODE(code));
  dfps_plant plant (.CLK(clk), .brk_o(brk_o), .brk_i(brk_i), .leak(leak),
    .bad(bad), .olo(olo), .ilo(ilo), .eft(eft), .psf(psf));

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // Shared helpers
  task cyc(input int n); repeat (n) @(posedge clk); endtask : cyc
  task nap(input int n); repeat (n) @(posedge clk); #1; endtask : nap
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Bounded wait on fault (0), output enable (1) or retry pulse (2)
  task wait_on(input int w, input int n);
    got = 1'b0;
    repeat (n) if (!got) begin
      @(negedge clk);
      got = (w == 0) ? (flt === 1'b1) : (w == 1) ? (oe === 1'b1) : (rr === 1'b1);
    end
  endtask : wait_on
  task do_reset(); rst_n <= 1'b0; cyc(5); rst_n <= 1'b1; cyc(1); endtask : do_reset
  task go(); cyc(1); start <= 1'b0; cyc(2); start <= 1'b1; endtask : go
  task clear(); cyc(1); start <= 1'b0; wr_reg(`DFPS_ADDR_CMD, 16'h0001); nap(2); endtask : clear

  // ==========================================================
  // Scenarios
  task t_reset();
    rd_reg(`DFPS_ADDR_CTRL, v); chk(v, 16'h0003);
    rd_reg(`DFPS_ADDR_MODE, v); chk(v, 16'h0000);
    rd_reg(`DFPS_ADDR_WAIT, v); chk(v, 16'h000a);
    rd_reg(`DFPS_ADDR_GROUP, v); chk(v, 16'h0000);
    rd_reg(4'hf, v); chk(v, 16'h0000);
  endtask : t_reset
  task t_regs();
    wr_reg(`DFPS_ADDR_GROUP, 16'h0001); wr_reg(`DFPS_ADDR_CTRL, 16'h0000); wr_reg(`DFPS_ADDR_MODE, 16'h0009);
    rd_reg(`DFPS_ADDR_CTRL, v); chk(v, 16'h0003);
    rd_reg(`DFPS_ADDR_MODE, v); chk(v, 16'h0000);
    wr_reg(`DFPS_ADDR_GROUP, 16'h0000); wr_reg(`DFPS_ADDR_MODE, 16'h0005);
    rd_reg(`DFPS_ADDR_MODE, v); chk(v, 16'h0000);
    wr_reg(`DFPS_ADDR_MODE, 16'h0009); nap(2); chk(16'(opt), 16'h0001);
    cyc(1); drive.restart_active <= 1'b1; nap(2); chk(16'(opt), 16'h0000);
    cyc(1); drive.restart_active <= 1'b0; drive.vf_control <= 1'b0; nap(2); chk(16'(opt), 16'h0000);
    cyc(1); drive.vf_control <= 1'b1; wr_reg(`DFPS_ADDR_MODE, 16'h0000); nap(2); chk(16'(opt), 16'h0000);
    wr_reg(`DFPS_ADDR_WAIT, 16'h0000); rd_reg(`DFPS_ADDR_WAIT, v); chk(v, 16'h0001);
    wr_reg(`DFPS_ADDR_WAIT, 16'h0fff); rd_reg(`DFPS_ADDR_WAIT, v); chk(v, 16'h0e10);
    wr_reg(`DFPS_ADDR_WAIT, 16'h000a);
  endtask : t_regs
  task t_out_loss();
    go(); wait_on(1, 10); chk(16'(got), 16'h0001);
    cyc(1); drive.freq_above_1hz <= 1'b0; brk_o <= 1'b1; nap(12); chk(16'(flt), 16'h0000);
    cyc(1); drive.freq_above_1hz <= 1'b1; drive.dc_braking <= 1'b1; nap(12); chk(16'(flt), 16'h0000);
    cyc(1); drive.dc_braking <= 1'b0; wait_on(0, 10); chk(16'(got), 16'h0001);
    chk(16'(code), 16'(`DFPS_CODE_OUT_LOSS));
    chk(16'(oe), 16'h0000);
    cyc(1); brk_o <= 1'b0; nap(8); chk(16'(flt), 16'h0001);
    clear(); chk(16'(flt), 16'h0000);
    wr_reg(`DFPS_ADDR_CTRL, 16'h0002); go(); brk_o <= 1'b1; nap(15); chk(16'(flt), 16'h0000);
    cyc(1); brk_o <= 1'b0; clear(); wr_reg(`DFPS_ADDR_CTRL, 16'h0003);
  endtask : t_out_loss
  task t_in_loss();
    go(); brk_i <= 1'b1; cyc(15); brk_i <= 1'b0; nap(10); chk(16'(flt), 16'h0000);
    cyc(1); drive.regenerating <= 1'b1; brk_i <= 1'b1; nap(40); chk(16'(flt), 16'h0000);
    cyc(1); drive.regenerating <= 1'b0; drive.light_load <= 1'b1; nap(40); chk(16'(flt), 16'h0000);
    cyc(1); drive.light_load <= 1'b0; drive.running <= 1'b0; nap(40); chk(16'(flt), 16'h0000);
    cyc(1); drive.running <= 1'b1; wait_on(0, 40); chk(16'(got), 16'h0001);
    chk(16'(code), 16'(`DFPS_CODE_IN_LOSS));
    cyc(1); brk_i <= 1'b0; clear();
    wr_reg(`DFPS_ADDR_CTRL, 16'h0001); go(); brk_i <= 1'b1; nap(40); chk(16'(flt), 16'h0000);
    cyc(1); brk_i <= 1'b0; wr_reg(`DFPS_ADDR_CTRL, 16'h0003); clear();
  endtask : t_in_loss
  task t_earth();
    cyc(1); leak <= 1'b1; go(); nap(15); chk(16'(flt), 16'h0000);
    cyc(1); leak <= 1'b0; clear();
    wr_reg(`DFPS_ADDR_CTRL, 16'h0007); go();
    wait_on(1, EC - 2); chk(16'(got), 16'h0000);
    wait_on(1, 20); chk(16'(got), 16'h0001);
    cyc(1); leak <= 1'b1; nap(12); chk(16'(flt), 16'h0000);
    go(); wait_on(0, 30); chk(16'(got), 16'h0001);
    chk(16'(code), 16'(`DFPS_CODE_EARTH));
    cyc(1); leak <= 1'b0; wr_reg(`DFPS_ADDR_CTRL, 16'h0003); clear();
  endtask : t_earth
  task t_retry();
    rd_reg(`DFPS_ADDR_ACCUM, a0);
    cyc(1); retry.retry_enable <= 1'b1; retry.ext_retry_ok <= 1'b1; go(); wait_on(1, 10);
    cyc(1); brk_o <= 1'b1; wait_on(0, 10);
    cyc(1); brk_o <= 1'b0; wait_on(2, 40); chk(16'(got), 16'h0000);
    wait_on(2, 30); chk(16'(got), 16'h0001);
    rd_reg(`DFPS_ADDR_ACCUM, v); chk(v, a0);
    go(); brk_i <= 1'b1; wait_on(0, 40); chk(16'(code), 16'(`DFPS_CODE_IN_LOSS));
    rd_reg(`DFPS_ADDR_FIRST, v); chk(v, 16'(`DFPS_CODE_OUT_LOSS));
    cyc(1); retry.ext_retry_ok <= 1'b0; retry.ext_fault <= 1'b1;
    wait_on(2, 100); chk(16'(got), 16'h0000);
    chk(16'(flt), 16'h0001);
    rd_reg(`DFPS_ADDR_STATUS, v); chk(v & 16'h0007, 16'h0003);
    cyc(1); brk_i <= 1'b0; retry <= '0; clear();
    rd_reg(`DFPS_ADDR_ACCUM, v); chk(v, a0 + 16'h0001);
  endtask : t_retry
  task t_store();
    cyc(1); bad <= 1'b1; retry.retry_enable <= 1'b1; retry.ext_retry_ok <= 1'b1; do_reset();
    wait_on(0, 20); chk(16'(code), 16'(`DFPS_CODE_STORE));
    wait_on(2, 100); chk(16'(got), 16'h0000);
    cyc(1); bad <= 1'b0; retry <= '0; do_reset();
  endtask : t_store

  // ==========================================================
  // Verdict and end of run
  task final_report();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    {rst_n, wr, rd, start, brk_o, brk_i, leak, bad} = '0;
    addr = '0; wdata = '0; retry = '0; drive = 7'h43;
    err_total = 0; samples_checked = 0;
    do_reset();
    t_reset(); t_regs(); t_out_loss(); t_in_loss(); t_earth(); t_retry(); t_store();
    final_report();
  end

  // Watchdog against a hang
  initial begin
    #(25 * 20000);
    err_total++;
    final_report();
  end
endmodule : dfps_tb_top
